// [rtl/tim_defs.vh]
// Purpose: constants of the temperature input register bank
// Assumes: addresses are the printed protocol addresses, coils in their own space
// Notes: holding copies of read-only data sit at input address plus the mirror step
// Behaviour
// - per-channel temperature, read-only, both spaces
// - per-channel float temperature, two words, both spaces
// - sixteen read/write sensor type registers
// - host watchdog timeout 5..65535 s, 0 off
// - watchdog expiry count readable in both spaces
// - idle connection timeout 5..65535 s, 0 off
// - auto-reset timeout 30..65535 s, 0 off
// - per-channel temperature offset in 0.01 degC
// - per-channel resistance offset in 0.01 ohm
// - per-channel resistance readout, both spaces
// - channel enable bitmask, bit n is channel n
// - stored averaging depth 1..128, default 1
// - volatile averaging depth 1..128, default 1
// - per-channel high latched value, both spaces
// - per-channel low latched value, both spaces
// - read-only open-wire flag per channel
// - write 1 restores default configuration
// - write 1 sets unit identifier to 1
// - write 1 reboots the module
// - rate coil, 0 slow, 1 fast
// - write 1 reloads factory calibration
// - clear all or one high/low latch
`ifndef TIM_DEFS_VH
`define TIM_DEFS_VH
// coil space
`define TIM_OW_BASE 16'h0060
`define TIM_DEF_COIL 16'h007F
`define TIM_SID_COIL 16'h0080
`define TIM_BOOT_COIL 16'h0085
`define TIM_RATE_COIL 16'h008D
`define TIM_CAL_COIL 16'h008E
`define TIM_CLRH_ALL 16'h0117
`define TIM_CLRL_ALL 16'h0118
`define TIM_CLRH_BASE 16'h0180
`define TIM_CLRL_BASE 16'h01A0
// register space, input copies
`define TIM_TEMP_BASE 16'h7530
`define TIM_DI_CNT 16'h7594
`define TIM_DO_CNT 16'h759E
`define TIM_AI_CNT 16'h75A8
`define TIM_AO_CNT 16'h75B2
`define TIM_FW_VER 16'h75C7
`define TIM_ALIAS_BASE 16'h75E4
`define TIM_WDT_CNT 16'h7632
`define TIM_NAME_BASE 16'h7633
`define TIM_FLT_BASE 16'h7670
`define TIM_RES_BASE 16'h76D0
`define TIM_HI_BASE 16'h7730
`define TIM_LO_BASE 16'h7750
`define TIM_MIRROR 16'h2710
`define TIM_HOLD_START 16'h9C40
// register space, holding only
`define TIM_TYPE_BASE 16'h9D14
`define TIM_WDT_TO 16'h9D41
`define TIM_TCP_TO 16'h9D47
`define TIM_ARST_TO 16'h9D48
`define TIM_TOFS_BASE 16'h9D60
`define TIM_ROFS_BASE 16'h9DC0
`define TIM_CHEN 16'h9E29
`define TIM_AVG 16'h9E31
`define TIM_AVGV 16'h9E34
// value limits and reset values
`define TIM_TO_MIN 16'h0005
`define TIM_ARST_MIN 16'h001E
`define TIM_AVG_MAX 16'h0080
`define TIM_AVG_RST 16'h0001
`define TIM_CHEN_RST 16'hFFFF
`define TIM_TO_RST 16'h0000
`define TIM_UNIT_ID 8'h01
// timing
`define TIM_SEC_NS 1000000000
`define TIM_CLK_NS 4
`endif

// [rtl/tim_regs.v]
// Purpose: temperature input register bank with timers and latches
// Assumes: measurement side is on core_clk; one access per request
// Notes: holding copies of read-only data answer at input address + mirror
`timescale 1ns/1ps
`include "tim_defs.vh"
module tim_regs #(
    parameter SEC_CYCLES = `TIM_SEC_NS / `TIM_CLK_NS,
    parameter [15:0] FW_VERSION = 16'h0100, // arbitrary value
    parameter [15:0] NAME_HI = 16'h1234, // arbitrary value
    parameter [15:0] NAME_LO = 16'h5678, // arbitrary value
    parameter [15:0] N_DI = 16'h0000,
    parameter [15:0] N_DO = 16'h0000,
    parameter [15:0] N_AI = 16'h0010,
    parameter [15:0] N_AO = 16'h0000
) (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register access
    input wire acc_req,
    input wire acc_wr,
    input wire acc_coil,
    input wire [15:0] acc_addr,
    input wire [15:0] acc_wdata,
    output reg [15:0] acc_rdata,
    output reg acc_ack,
    output reg acc_err,
    // measurements
    input wire meas_valid,
    input wire [3:0] meas_chan,
    input wire [15:0] meas_temp,
    input wire [15:0] meas_res,
    input wire [31:0] meas_float,
    input wire [15:0] open_wire,
    // control towards the module
    output wire [15:0] chan_enable,
    output wire [7:0] avg_depth,
    output wire rate_fast,
    output reg [7:0] unit_id,
    output reg reboot_pulse,
    output reg defaults_pulse,
    output reg cal_reload_pulse,
    output reg tcp_drop_pulse,
    output reg wdt_trip_pulse,
    output wire [255:0] type_codes
);

////////////////////////////////////////////////////////////////////////////////
reg [15:0] temp_ff [0:15];
reg [15:0] res_ff [0:15];
reg [31:0] flt_ff [0:15];
reg [15:0] hi_ff [0:15];
reg [15:0] lo_ff [0:15];
reg [15:0] hi_vld_ff;
reg [15:0] lo_vld_ff;
reg [15:0] type_ff [0:15];
reg [15:0] tofs_ff [0:15];
reg [15:0] rofs_ff [0:15];
reg [15:0] chen_ff;
reg [15:0] avg_ff;
reg [15:0] avgv_ff;
reg [15:0] wdt_to_ff;
reg [15:0] tcp_to_ff;
reg [15:0] ars_to_ff;
reg rate_ff;
reg [15:0] trip_cnt_ff;
reg [31:0] div_ff;
reg [15:0] wdt_sec_ff;
reg [15:0] tcp_sec_ff;
reg [15:0] ars_sec_ff;
reg [15:0] rd;
reg ok;
reg ro;
reg bad_val;
wire [15:0] ra;
wire [15:0] ofs;
wire [15:0] flt_ix;
wire [15:0] typ_ix;
wire wr_go;
wire sec_tick;
wire [15:0] ctemp;
wire [15:0] cres;
integer i, j;

// range test helper
function inr;
    input [15:0] a;
    input [15:0] b;
    input [15:0] n;
    begin
        inr = (a >= b) && ((a - b) < n);
    end
endfunction

// holding copies of read-only data fold onto the input addresses
assign ra = (acc_addr >= `TIM_HOLD_START) ? acc_addr - `TIM_MIRROR : acc_addr;
assign ofs = acc_addr;
assign flt_ix = ra - `TIM_FLT_BASE;
assign typ_ix = ofs - `TIM_TYPE_BASE;
assign chan_enable = chen_ff;
assign avg_depth = avgv_ff[7:0];
assign rate_fast = rate_ff;
assign ctemp = meas_temp + tofs_ff[meas_chan];
assign cres = meas_res + rofs_ff[meas_chan];

genvar g;
generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_type
        assign type_codes[g*16 +: 16] = type_ff[g];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read decode, write legality
always @*
begin
    rd = 16'h0000;
    ok = 1'b0;
    ro = 1'b0;
    bad_val = 1'b0;
    if (acc_coil)
    begin
        if (inr(ofs, `TIM_OW_BASE, 16'h0010))
        begin
            rd = {15'h0000, open_wire[ofs[3:0]]};
            ok = 1'b1;
            ro = 1'b1;
        end
        else if (ofs == `TIM_RATE_COIL)
        begin
            rd = {15'h0000, rate_ff};
            ok = 1'b1;
        end
        else if (ofs == `TIM_DEF_COIL || ofs == `TIM_SID_COIL || ofs == `TIM_BOOT_COIL
                 || ofs == `TIM_CAL_COIL || ofs == `TIM_CLRH_ALL || ofs == `TIM_CLRL_ALL
                 || inr(ofs, `TIM_CLRH_BASE, 16'h0010)
                 || inr(ofs, `TIM_CLRL_BASE, 16'h0010))
            ok = 1'b1; // write-only coils read as zero
    end
    else
    begin
        ro = 1'b1;
        ok = 1'b1;
        if (inr(ra, `TIM_TEMP_BASE, 16'h0010))
            rd = temp_ff[ra[3:0]];
        else if (ra == `TIM_DI_CNT)
            rd = N_DI;
        else if (ra == `TIM_DO_CNT)
            rd = N_DO;
        else if (ra == `TIM_AI_CNT)
            rd = N_AI;
        else if (ra == `TIM_AO_CNT)
            rd = N_AO;
        else if (ra == `TIM_FW_VER)
            rd = FW_VERSION;
        else if (inr(ra, `TIM_ALIAS_BASE, 16'h000F))
            rd = 16'h0000;
        else if (ra == `TIM_WDT_CNT)
            rd = trip_cnt_ff;
        else if (inr(ra, `TIM_NAME_BASE, 16'h0002))
            rd = (ra == `TIM_NAME_BASE) ? NAME_HI : NAME_LO;
        else if (inr(ra, `TIM_FLT_BASE, 16'h0020))
            rd = flt_ix[0] ? flt_ff[flt_ix[4:1]][15:0] : flt_ff[flt_ix[4:1]][31:16];
        else if (inr(ra, `TIM_RES_BASE, 16'h0010))
            rd = res_ff[ra[3:0]];
        else if (inr(ra, `TIM_HI_BASE, 16'h0010))
            rd = hi_ff[ra[3:0]];
        else if (inr(ra, `TIM_LO_BASE, 16'h0010))
            rd = lo_ff[ra[3:0]];
        else
        begin
            ro = 1'b0;
            if (inr(ofs, `TIM_TYPE_BASE, 16'h0010))
                rd = type_ff[typ_ix[3:0]];
            else if (ofs == `TIM_WDT_TO || ofs == `TIM_TCP_TO)
            begin
                rd = (ofs == `TIM_WDT_TO) ? wdt_to_ff : tcp_to_ff;
                bad_val = (acc_wdata != 16'h0000) && (acc_wdata < `TIM_TO_MIN);
            end
            else if (ofs == `TIM_ARST_TO)
            begin
                rd = ars_to_ff;
                bad_val = (acc_wdata != 16'h0000) && (acc_wdata < `TIM_ARST_MIN);
            end
            else if (inr(ofs, `TIM_TOFS_BASE, 16'h0010))
                rd = tofs_ff[ofs[3:0]];
            else if (inr(ofs, `TIM_ROFS_BASE, 16'h0010))
                rd = rofs_ff[ofs[3:0]];
            else if (ofs == `TIM_CHEN)
                rd = chen_ff;
            else if (ofs == `TIM_AVG || ofs == `TIM_AVGV)
            begin
                rd = (ofs == `TIM_AVG) ? avg_ff : avgv_ff;
                bad_val = (acc_wdata == 16'h0000) || (acc_wdata > `TIM_AVG_MAX);
            end
            else
                ok = 1'b0;
        end
    end
end

assign wr_go = acc_req && acc_wr && ok && !ro && !bad_val;

////////////////////////////////////////////////////////////////////////////////
// access answer, one cycle after the request
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        acc_ack <= 1'b0;
        acc_err <= 1'b0;
        acc_rdata <= 16'h0000;
    end
    else
    begin
        acc_ack <= acc_req;
        acc_err <= acc_req && (!ok || (acc_wr && (ro || bad_val)));
        acc_rdata <= (acc_req && !acc_wr) ? rd : 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers and action coils
always @(posedge core_clk)
begin
    if (sys_rst || (wr_go && acc_coil && ofs == `TIM_DEF_COIL && acc_wdata[0]))
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            type_ff[i] <= 16'h0000;
            tofs_ff[i] <= 16'h0000;
            rofs_ff[i] <= 16'h0000;
        end
        chen_ff <= `TIM_CHEN_RST;
        avg_ff <= `TIM_AVG_RST;
        avgv_ff <= `TIM_AVG_RST;
        wdt_to_ff <= `TIM_TO_RST;
        tcp_to_ff <= `TIM_TO_RST;
        ars_to_ff <= `TIM_TO_RST;
        rate_ff <= 1'b0;
    end
    else if (wr_go && !acc_coil)
    begin
        if (inr(ofs, `TIM_TYPE_BASE, 16'h0010))
            type_ff[typ_ix[3:0]] <= acc_wdata;
        if (ofs == `TIM_WDT_TO)
            wdt_to_ff <= acc_wdata;
        if (ofs == `TIM_TCP_TO)
            tcp_to_ff <= acc_wdata;
        if (ofs == `TIM_ARST_TO)
            ars_to_ff <= acc_wdata;
        if (inr(ofs, `TIM_TOFS_BASE, 16'h0010))
            tofs_ff[ofs[3:0]] <= acc_wdata;
        if (inr(ofs, `TIM_ROFS_BASE, 16'h0010))
            rofs_ff[ofs[3:0]] <= acc_wdata;
        if (ofs == `TIM_CHEN)
            chen_ff <= acc_wdata;
        // the stored depth also sets the working depth
        if (ofs == `TIM_AVG)
        begin
            avg_ff <= acc_wdata;
            avgv_ff <= acc_wdata;
        end
        if (ofs == `TIM_AVGV)
            avgv_ff <= acc_wdata;
    end
    else if (wr_go && ofs == `TIM_RATE_COIL)
        rate_ff <= acc_wdata[0];
end

// one-shot actions
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        unit_id <= `TIM_UNIT_ID;
        defaults_pulse <= 1'b0;
        cal_reload_pulse <= 1'b0;
    end
    else
    begin
        defaults_pulse <= wr_go && acc_coil && ofs == `TIM_DEF_COIL && acc_wdata[0];
        cal_reload_pulse <= wr_go && acc_coil && ofs == `TIM_CAL_COIL && acc_wdata[0];
        if (wr_go && acc_coil && ofs == `TIM_SID_COIL && acc_wdata[0])
            unit_id <= `TIM_UNIT_ID;
    end
end

////////////////////////////////////////////////////////////////////////////////
// measurement capture and latches; a sample wins over a clear
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        hi_vld_ff <= 16'h0000;
        lo_vld_ff <= 16'h0000;
        for (j = 0; j < 16; j = j + 1)
        begin
            temp_ff[j] <= 16'h0000;
            res_ff[j] <= 16'h0000;
            flt_ff[j] <= 32'h0000_0000;
            hi_ff[j] <= 16'h0000;
            lo_ff[j] <= 16'h0000;
        end
    end
    else
    begin
        if (wr_go && acc_coil && acc_wdata[0])
        begin
            if (ofs == `TIM_CLRH_ALL)
                hi_vld_ff <= 16'h0000;
            if (ofs == `TIM_CLRL_ALL)
                lo_vld_ff <= 16'h0000;
            if (inr(ofs, `TIM_CLRH_BASE, 16'h0010))
                hi_vld_ff[ofs[3:0]] <= 1'b0;
            if (inr(ofs, `TIM_CLRL_BASE, 16'h0010))
                lo_vld_ff[ofs[3:0]] <= 1'b0;
        end
        if (meas_valid && chen_ff[meas_chan])
        begin
            temp_ff[meas_chan] <= ctemp;
            res_ff[meas_chan] <= cres;
            flt_ff[meas_chan] <= meas_float;
            hi_vld_ff[meas_chan] <= 1'b1;
            lo_vld_ff[meas_chan] <= 1'b1;
            if (!hi_vld_ff[meas_chan] || $signed(ctemp) > $signed(hi_ff[meas_chan]))
                hi_ff[meas_chan] <= ctemp;
            if (!lo_vld_ff[meas_chan] || $signed(ctemp) < $signed(lo_ff[meas_chan]))
                lo_ff[meas_chan] <= ctemp;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// one-second tick
assign sec_tick = (div_ff == SEC_CYCLES - 1);

always @(posedge core_clk)
begin
    if (sys_rst || sec_tick)
        div_ff <= 32'h0000_0000;
    else
        div_ff <= div_ff + 32'h0000_0001;
end

// host activity timers; any request restarts them
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        wdt_sec_ff <= 16'h0000;
        tcp_sec_ff <= 16'h0000;
        ars_sec_ff <= 16'h0000;
        trip_cnt_ff <= 16'h0000;
        wdt_trip_pulse <= 1'b0;
        tcp_drop_pulse <= 1'b0;
        reboot_pulse <= 1'b0;
    end
    else
    begin
        wdt_trip_pulse <= 1'b0;
        tcp_drop_pulse <= 1'b0;
        reboot_pulse <= wr_go && acc_coil && ofs == `TIM_BOOT_COIL && acc_wdata[0];
        if (acc_req)
        begin
            wdt_sec_ff <= 16'h0000;
            tcp_sec_ff <= 16'h0000;
            ars_sec_ff <= 16'h0000;
        end
        else if (sec_tick)
        begin
            if (wdt_to_ff != 16'h0000 && wdt_sec_ff + 16'h0001 >= wdt_to_ff)
            begin
                wdt_sec_ff <= 16'h0000;
                wdt_trip_pulse <= 1'b1;
                trip_cnt_ff <= trip_cnt_ff + 16'h0001;
            end
            else if (wdt_sec_ff != 16'hFFFF)
                wdt_sec_ff <= wdt_sec_ff + 16'h0001;
            if (tcp_to_ff != 16'h0000 && tcp_sec_ff + 16'h0001 >= tcp_to_ff)
            begin
                tcp_sec_ff <= 16'h0000;
                tcp_drop_pulse <= 1'b1;
            end
            else if (tcp_sec_ff != 16'hFFFF)
                tcp_sec_ff <= tcp_sec_ff + 16'h0001;
            if (ars_to_ff != 16'h0000 && ars_sec_ff + 16'h0001 >= ars_to_ff)
            begin
                ars_sec_ff <= 16'h0000;
                reboot_pulse <= 1'b1;
            end
            else if (ars_sec_ff != 16'hFFFF)
                ars_sec_ff <= ars_sec_ff + 16'h0001;
        end
    end
end

endmodule // tim_regs

// [tb/tim_regs_sva.sv]
// Purpose: port checks of the temperature register bank
// Assumes: one clock, synchronous reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "tim_defs.vh"
module tim_regs_sva (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // access
    input wire acc_req,
    input wire acc_wr,
    input wire acc_coil,
    input wire [15:0] acc_addr,
    input wire [15:0] acc_wdata,
    input wire [15:0] acc_rdata,
    input wire acc_ack,
    input wire acc_err,
    // control
    input wire [7:0] avg_depth,
    input wire rate_fast,
    input wire [7:0] unit_id,
    input wire reboot_pulse,
    input wire defaults_pulse,
    input wire cal_reload_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // request classes
    wire coil_set = acc_req && acc_wr && acc_coil && acc_wdata[0];
    wire reg_wr = acc_req && acc_wr && !acc_coil;
    wire dep_wr = reg_wr && acc_addr == `TIM_AVGV;
    property p_ack;
        acc_req |=> acc_ack;
    endproperty
    property p_idle;
        !acc_req |=> !acc_ack && !acc_err;
    endproperty
    property p_wr_zero;
        acc_req && acc_wr |=> acc_rdata == 16'h0000;
    endproperty
    property p_ro;
        reg_wr && acc_addr[15:4] == 12'h753 |=> acc_err;
    endproperty
    property p_dep_bad;
        dep_wr && (acc_wdata == 16'h0 || acc_wdata > 16'h80) |=> acc_err && $stable(avg_depth);
    endproperty
    property p_dep_ok;
        dep_wr && acc_wdata != 16'h0 && acc_wdata <= 16'h80
            |=> !acc_err && avg_depth == $past(acc_wdata[7:0]);
    endproperty
    property p_boot;
        coil_set && acc_addr == `TIM_BOOT_COIL |=> reboot_pulse;
    endproperty
    property p_def;
        coil_set && acc_addr == `TIM_DEF_COIL |=> defaults_pulse;
    endproperty
    property p_cal;
        coil_set && acc_addr == `TIM_CAL_COIL |=> cal_reload_pulse;
    endproperty
    property p_sid;
        coil_set && acc_addr == `TIM_SID_COIL |=> unit_id == 8'h01;
    endproperty
    property p_rate;
        acc_req && acc_wr && acc_coil && acc_addr == `TIM_RATE_COIL
            |=> rate_fast == $past(acc_wdata[0]);
    endproperty
    a_ack: assert property (p_ack) else $error("no answer after request");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_wr_zero: assert property (p_wr_zero) else $error("write answer data not zero");
    a_ro: assert property (p_ro) else $error("read-only write accepted");
    a_dep_bad: assert property (p_dep_bad) else $error("bad depth taken");
    a_dep_ok: assert property (p_dep_ok) else $error("depth not applied");
    a_boot: assert property (p_boot) else $error("no reboot pulse");
    a_def: assert property (p_def) else $error("no defaults pulse");
    a_cal: assert property (p_cal) else $error("no calibration pulse");
    a_sid: assert property (p_sid) else $error("unit id not one");
    a_rate: assert property (p_rate) else $error("rate not applied");
    c_boot: cover property (coil_set && acc_addr == `TIM_BOOT_COIL);
    c_dep: cover property (dep_wr ##1 acc_err);
    c_err: cover property (acc_ack && acc_err);
endmodule // tim_regs_sva

// [tb/tim_host.sv]
// Purpose: register client model facing the bank
// Assumes: one request pulse per access
// Notes: released address and data are inverted
`timescale 1ns/1ps
module tim_host (
    // clock
    input wire core_clk,
    // requests
    output reg acc_req,
    output reg acc_wr,
    output reg acc_coil,
    output reg [15:0] acc_addr,
    output reg [15:0] acc_wdata,
    // answers
    input wire [15:0] acc_rdata,
    input wire acc_ack,
    input wire acc_err
);
    initial
    begin
        acc_req = 1'b0;
        acc_wr = 1'b0;
        acc_coil = 1'b0;
        acc_addr = 16'h0000;
        acc_wdata = 16'h0000;
    end
    // one access, answer looked for under a bound
    task access(input w, input c, input [15:0] a, input [15:0] d,
                output [15:0] r, output e, output ok);
        integer n;
        begin
            @(posedge core_clk);
            acc_req <= 1'b1;
            acc_wr <= w;
            acc_coil <= c;
            acc_addr <= a;
            acc_wdata <= d;
            @(posedge core_clk);
            acc_req <= 1'b0;
            acc_addr <= ~a;
            acc_wdata <= ~d;
            ok = 1'b0;
            r = 16'h0000;
            e = 1'b0;
            for (n = 0; n < 4 && !ok; n = n + 1)
            begin
                @(posedge core_clk);
                if (acc_ack === 1'b1)
                begin
                    ok = 1'b1;
                    r = acc_rdata;
                    e = acc_err;
                end
            end
        end
    endtask
endmodule // tim_host

// [tb/tim_regs_tb.sv]
// Purpose: self-checking bench of the register bank
// Assumes: one second is ten clocks here
// Notes: random data from a fixed-seed shift register
`timescale 1ns/1ps
`include "tim_defs.vh"
module tim_regs_tb;
    reg core_clk, sys_rst, meas_valid;
    reg [3:0] meas_chan;
    reg [15:0] meas_temp, meas_res, open_wire, t, v, o, rd;
    reg [31:0] meas_float, seed;
    reg er, ok, sw, st;
    reg [15:0] hi_e [0:15];
    reg [15:0] lo_e [0:15];
    wire acc_req, acc_wr, acc_coil, acc_ack, acc_err, rate_fast;
    wire reboot_pulse, defaults_pulse, cal_reload_pulse, tcp_drop_pulse, wdt_trip_pulse;
    wire [15:0] acc_addr, acc_wdata, acc_rdata, chan_enable;
    wire [7:0] avg_depth, unit_id;
    wire [255:0] type_codes;
    integer bad_count, n_tests, i, k;
    tim_regs #(.SEC_CYCLES(10)) tim_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .acc_req(acc_req), .acc_wr(acc_wr), .acc_coil(acc_coil), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
        .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_temp(meas_temp),
        .meas_res(meas_res), .meas_float(meas_float), .open_wire(open_wire),
        .chan_enable(chan_enable), .avg_depth(avg_depth), .rate_fast(rate_fast),
        .unit_id(unit_id), .reboot_pulse(reboot_pulse), .defaults_pulse(defaults_pulse),
        .cal_reload_pulse(cal_reload_pulse), .tcp_drop_pulse(tcp_drop_pulse),
        .wdt_trip_pulse(wdt_trip_pulse), .type_codes(type_codes));
    tim_host tim_host_inst (.core_clk(core_clk), .acc_req(acc_req), .acc_wr(acc_wr),
        .acc_coil(acc_coil), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err));
    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [15:0] smax(input [15:0] a, input [15:0] b);
        smax = ($signed(a) > $signed(b)) ? a : b;
    endfunction
    function [15:0] smin(input [15:0] a, input [15:0] b);
        smin = ($signed(a) < $signed(b)) ? a : b;
    endfunction
    task rnd(output [15:0] r);
        seed = lfsr(seed);
        r = seed[15:0];
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
        end
    endtask
    // access with expected error flag
    task acc(input w, input c, input [15:0] a, input [15:0] d, input e);
        tim_host_inst.access(w, c, a, d, rd, er, ok);
        chk("ack", 16'h0001, {15'h0, ok});
        if (!ok)
            finish_test;
        chk("err", {15'h0, e}, {15'h0, er});
    endtask
    task rdc(input c, input [15:0] a, input [15:0] e);
        acc(1'b0, c, a, 16'h0000, 1'b0);
        chk("rdata", e, rd);
    endtask
    task smp(input [3:0] c, input [15:0] tv, input [15:0] rv);
        @(posedge core_clk);
        meas_valid <= 1'b1;
        meas_chan <= c;
        meas_temp <= tv;
        meas_res <= rv;
        meas_float <= {tv, rv};
        @(posedge core_clk);
        meas_valid <= 1'b0;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        bad_count = 0;
        n_tests = 0;
        seed = 32'hDFB1;
        sys_rst = 1'b1;
        meas_valid = 1'b0;
        meas_chan = 4'h0;
        meas_temp = 16'h0000;
        meas_res = 16'h0000;
        meas_float = 32'h0;
        open_wire = 16'h0000;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk("enable", 16'hFFFF, chan_enable);
        rdc(1'b0, `TIM_AVG, 16'h0001);
        rdc(1'b0, `TIM_AVGV, 16'h0001);
        acc(1'b1, 1'b1, `TIM_CLRH_ALL, 16'h0001, 1'b0);
        acc(1'b1, 1'b1, `TIM_CLRL_ALL, 16'h0001, 1'b0);
        // two random samples per channel, then every readout
        for (k = 0; k < 32; k = k + 1)
        begin
            rnd(t);
            rnd(v);
            smp(k[3:0], t, v);
            hi_e[k % 16] = (k < 16) ? t : smax(hi_e[k % 16], t);
            lo_e[k % 16] = (k < 16) ? t : smin(lo_e[k % 16], t);
            if (k >= 16)
            begin
                rdc(1'b0, `TIM_TEMP_BASE + k - 16, t);
                rdc(1'b0, `TIM_TEMP_BASE + `TIM_MIRROR + k - 16, t);
                rdc(1'b0, `TIM_RES_BASE + `TIM_MIRROR + k - 16, v);
                rdc(1'b0, `TIM_FLT_BASE + 2 * (k - 16), t);
                rdc(1'b0, `TIM_FLT_BASE + `TIM_MIRROR + 2 * (k - 16) + 1, v);
                rdc(1'b0, `TIM_HI_BASE + k - 16, hi_e[k - 16]);
                rdc(1'b0, `TIM_LO_BASE + `TIM_MIRROR + k - 16, lo_e[k - 16]);
            end
        end
        acc(1'b1, 1'b0, `TIM_TEMP_BASE, 16'h0001, 1'b1);
        acc(1'b1, 1'b1, `TIM_CLRH_BASE + 3, 16'h0001, 1'b0);
        acc(1'b1, 1'b1, `TIM_CLRL_BASE + 5, 16'h0001, 1'b0);
        rnd(t);
        smp(4'h3, t, 16'h0);
        smp(4'h5, t, 16'h0);
        rdc(1'b0, `TIM_HI_BASE + 3, t);
        rdc(1'b0, `TIM_LO_BASE + 3, smin(lo_e[3], t));
        rdc(1'b0, `TIM_LO_BASE + 5, t);
        // offsets on channel 2, float stays raw
        rnd(o);
        acc(1'b1, 1'b0, `TIM_TOFS_BASE + 2, o, 1'b0);
        acc(1'b1, 1'b0, `TIM_ROFS_BASE + 2, ~o, 1'b0);
        rnd(t);
        rnd(v);
        smp(4'h2, t, v);
        rdc(1'b0, `TIM_TEMP_BASE + 2, t + o);
        rdc(1'b0, `TIM_RES_BASE + 2, v + ~o);
        rdc(1'b0, `TIM_FLT_BASE + 4, t);
        // channel 4 disabled ignores its sample
        smp(4'h4, t, 16'h0);
        acc(1'b1, 1'b0, `TIM_CHEN, 16'hFFEF, 1'b0);
        rdc(1'b0, `TIM_CHEN, 16'hFFEF);
        rdc(1'b0, `TIM_TEMP_BASE + 4, t);
        smp(4'h4, ~t, 16'h0);
        rdc(1'b0, `TIM_TEMP_BASE + 4, t);
        for (i = 0; i < 16; i = i + 1)
        begin
            rnd(t);
            acc(1'b1, 1'b0, `TIM_TYPE_BASE + i, t, 1'b0);
            rdc(1'b0, `TIM_TYPE_BASE + i, t);
            chk("type", t, type_codes[16 * i +: 16]);
        end
        // each timeout: below minimum refused, minimum taken
        for (k = 0; k < 3; k = k + 1)
        begin
            t = (k == 0) ? `TIM_WDT_TO : (k == 1) ? `TIM_TCP_TO : `TIM_ARST_TO;
            v = (k == 2) ? `TIM_ARST_MIN : `TIM_TO_MIN;
            acc(1'b1, 1'b0, t, v - 16'h1, 1'b1);
            acc(1'b1, 1'b0, t, v, 1'b0);
            rdc(1'b0, t, v);
        end
        sw = 1'b0;
        st = 1'b0;
        for (k = 0; k < 100 && !(sw && st); k = k + 1)
        begin
            @(posedge core_clk);
            sw = sw | (wdt_trip_pulse === 1'b1);
            st = st | (tcp_drop_pulse === 1'b1);
        end
        chk("trip", 16'h0001, {15'h0, sw});
        chk("drop", 16'h0001, {15'h0, st});
        if (!(sw && st))
            finish_test;
        acc(1'b1, 1'b0, `TIM_WDT_TO, 16'h0000, 1'b0);
        repeat (60) @(posedge core_clk);
        rdc(1'b0, `TIM_WDT_CNT + `TIM_MIRROR, 16'h0001);
        acc(1'b1, 1'b0, `TIM_AVGV, 16'h0000, 1'b1);
        acc(1'b1, 1'b0, `TIM_AVGV, 16'h0081, 1'b1);
        acc(1'b1, 1'b0, `TIM_AVGV, 16'h0080, 1'b0);
        acc(1'b1, 1'b0, `TIM_AVG, 16'h0081, 1'b1);
        acc(1'b1, 1'b0, `TIM_AVG, 16'h0080, 1'b0);
        rdc(1'b0, `TIM_AVG, 16'h0080);
        rnd(t);
        open_wire <= t;
        for (i = 0; i < 16; i = i + 1)
            rdc(1'b1, `TIM_OW_BASE + i, {15'h0, t[i]});
        acc(1'b1, 1'b1, `TIM_OW_BASE, 16'h0001, 1'b1);
        acc(1'b1, 1'b1, `TIM_RATE_COIL, 16'h0001, 1'b0);
        rdc(1'b1, `TIM_RATE_COIL, 16'h0001);
        acc(1'b1, 1'b1, `TIM_RATE_COIL, 16'h0000, 1'b0);
        rdc(1'b1, `TIM_RATE_COIL, 16'h0000);
        acc(1'b1, 1'b1, `TIM_CAL_COIL, 16'h0001, 1'b0);
        acc(1'b1, 1'b1, `TIM_SID_COIL, 16'h0001, 1'b0);
        acc(1'b1, 1'b1, `TIM_DEF_COIL, 16'h0001, 1'b0);
        rdc(1'b0, `TIM_CHEN, 16'hFFFF);
        rdc(1'b0, `TIM_AVGV, 16'h0001);
        rdc(1'b1, `TIM_DEF_COIL, 16'h0000);
        acc(1'b1, 1'b1, `TIM_BOOT_COIL, 16'h0001, 1'b0);
        acc(1'b0, 1'b0, 16'h1234, 16'h0000, 1'b1);
        finish_test;
    end
endmodule // tim_regs_tb
bind tim_regs tim_regs_sva tim_regs_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .acc_req(acc_req), .acc_wr(acc_wr), .acc_coil(acc_coil), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
    .avg_depth(avg_depth), .rate_fast(rate_fast), .unit_id(unit_id),
    .reboot_pulse(reboot_pulse), .defaults_pulse(defaults_pulse),
    .cal_reload_pulse(cal_reload_pulse));
